// *** spi_defs.svh ***
// Control byte field positions and fixed codes of the serial controller.
// Included by the controller; holds definitions only.
`ifndef SPI_DEFS_SVH
`define SPI_DEFS_SVH

// ----------------------------------------------------------------------
// Control byte layout
// ----------------------------------------------------------------------
`define CTRL_RATE0_BIT 0
`define CTRL_RATE1_BIT 1
`define CTRL_PHASE_BIT 2
`define CTRL_POLARITY_BIT 3
`define CTRL_MASTER_BIT 4
`define CTRL_SELECT_PIN_DISABLE_BIT 5
`define CTRL_ENABLE_BIT 6
`define CTRL_RATE2_BIT 7

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define CTRL_RESET 8'h00
`define RATE_FULL_CODE 3'h7
`define LAST_EDGE 4'hF
`define FIFO_DEPTH 16
`define DATA_WIDTH 8

`endif

// *** spi_pkg.sv ***
// Types shared by the serial controller files.
// Assumes spi_defs.svh is reachable on the include path.
package spi_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] rate_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MSHIFT = 2'b01,
        ST_SSHIFT = 2'b10
    } state_t;
endpackage

// *** spi_rate_div.sv ***
// Bit rate divider: one-cycle tick at each serial clock half period.
// Runs only while run is high; restarts from zero when run drops.
`timescale 1ns/1ns
`default_nettype none
`include "spi_defs.svh"
module spi_rate_div (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire spi_pkg::rate_t rateSel,
    output logic tick
);
    import spi_pkg::*;
    logic [5:0] count;
    logic [5:0] next_count;
    logic [5:0] limit;
    logic [6:0] span;

    // Half period of 2^code cycles; the full-rate code is held at /2
    always_comb begin
        span = (rateSel == `RATE_FULL_CODE) ? 7'h01 : (7'h01 << rateSel);
        limit = 6'(span - 7'h01);
        tick = run && (count == limit);
        next_count = (!run || tick) ? 6'h00 : 6'(count + 6'h01);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= 6'h00;
        end else begin
            count <= next_count;
        end
    end
endmodule // spi_rate_div
`default_nettype wire

// *** spi_fifo.sv ***
// Receive buffer: flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; a push and a pop may share a cycle.
`timescale 1ns/1ns
`default_nettype none
module spi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wrValid,
    output logic wrReady,
    input wire logic [WIDTH-1:0] wrData,
    output logic rdValid,
    input wire logic rdReady,
    output logic [WIDTH-1:0] rdData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    logic [AW:0] next_wrPtr;
    logic [AW:0] next_rdPtr;
    logic push;
    logic pop;

    always_comb begin
        wrReady = (wrPtr[AW] == rdPtr[AW]) || (wrPtr[AW-1:0] != rdPtr[AW-1:0]);
        rdValid = (wrPtr != rdPtr);
        push = wrValid && wrReady;
        pop = rdValid && rdReady;
        next_wrPtr = push ? (AW+1)'(wrPtr + 1'b1) : wrPtr;
        next_rdPtr = pop ? (AW+1)'(rdPtr + 1'b1) : rdPtr;
        rdData = mem[rdPtr[AW-1:0]];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
        end
        if (push) begin
            mem[wrPtr[AW-1:0]] <= wrData;
        end
    end
endmodule // spi_fifo
`default_nettype wire

// *** spi_ctrl.sv ***
// Byte serial controller, master or slave, with control/status/data ports.
// Assumes pins arrive from outside the clock domain; software strobes
// are one-cycle pulses on clk.
// Notes on behaviour
// - Master drives out-line; selected slave drives in-line, here only once a byte is preloaded.
// - Master makes eight clock cycles per byte.
// - Master select bit set means master mode.
// - Only master starts; data write launches it.
// - Write loads shifter; read returns receive buffer.
// - Rate generator paces shifting and clock output.
// - Most significant bit goes first.
// - Master captures incoming byte while shifting out.
// - Every finished byte sets done flag.
// - Master select-disable frees select pin.
// - Slave only when not master and loaded.
// - Slave shifts out-line in on received clock.
// - Slave shifts preloaded byte out on in-line.
// - Slave select-disable acts only with phase one.
// - Slave selection stays with software port pins.
// - Rate code picks divide by 2..128, or 2 for code 7.
// - Polarity sets idle level; disabled idles high.
// - Foreign select low in master: fault, disable, slave.
// - Write during transfer dropped, collision flag set.
`timescale 1ns/1ns
`default_nettype none
`include "spi_defs.svh"
module spi_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ctrlWr,
    input wire spi_pkg::byte_t ctrlIn,
    input wire logic statusRd,
    input wire logic dataWr,
    input wire spi_pkg::byte_t dataIn,
    input wire logic dataRd,
    output spi_pkg::byte_t rxData,
    output logic rxValid,
    output logic peripheralEnable,
    output logic masterSelect,
    output logic transferDone,
    output logic modeFault,
    output logic writeCollision,
    output logic spiRequest,
    output logic ssPinRelease,
    input wire logic ssIn,
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOe,
    input wire logic mosiIn,
    output logic mosiOut,
    output logic mosiOe,
    input wire logic misoIn,
    output logic misoOut,
    output logic misoOe
);
    import spi_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [3:0] pinMeta;
    logic ssSync;
    logic sckSync;
    logic mosiSync;
    logic misoSync;
    logic sckPrev;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pinMeta <= 4'hF;
            {ssSync, sckSync, mosiSync, misoSync} <= 4'hF;
            sckPrev <= 1'b1;
        end else begin
            pinMeta <= {ssIn, sckIn, mosiIn, misoIn};
            {ssSync, sckSync, mosiSync, misoSync} <= pinMeta;
            sckPrev <= sckSync;
        end
    end

    // ------------------------------------------------------------------
    // Control, shifter and flags
    // ------------------------------------------------------------------
    rate_t rateSel;
    logic clockPhase;
    logic clockPolarity;
    logic selectPinDisable;
    state_t state;
    byte_t shiftReg;
    logic [3:0] edgeIdx;
    logic sckPhase;
    logic slaveArmed;
    logic statusSeen;
    rate_t next_rateSel;
    logic next_clockPhase;
    logic next_clockPolarity;
    logic next_selectPinDisable;
    logic next_peripheralEnable;
    logic next_masterSelect;
    state_t next_state;
    byte_t next_shiftReg;
    logic [3:0] next_edgeIdx;
    logic next_sckPhase;
    logic next_mosiOut;
    logic next_slaveArmed;
    logic next_statusSeen;
    logic next_transferDone;
    logic next_modeFault;
    logic next_writeCollision;
    logic tick;
    logic fifoReady;
    logic busy;
    logic slaveSelected;
    logic faultEvent;
    logic sckEdge;
    logic sampleEdge;
    logic inBit;
    logic xferDone;
    byte_t capture;
    byte_t pushByte;

    spi_rate_div rateDiv (
        .clk(clk),
        .rst_n(rst_n),
        .run(state == ST_MSHIFT),
        .rateSel(rateSel),
        .tick(tick)
    );

    spi_fifo #(
        .WIDTH(`DATA_WIDTH),
        .DEPTH(`FIFO_DEPTH)
    ) rxFifo (
        .clk(clk),
        .rst_n(rst_n),
        .wrValid(xferDone),
        .wrReady(fifoReady),
        .wrData(pushByte),
        .rdValid(rxValid),
        .rdReady(dataRd),
        .rdData(rxData)
    );

    always_comb begin
        busy = (state != ST_IDLE);
        ssPinRelease = selectPinDisable && (masterSelect || clockPhase);
        slaveSelected = !ssSync || ssPinRelease;
        faultEvent = peripheralEnable && masterSelect && !selectPinDisable
            && !ssSync;
        // Slave edges come from the synchronised clock pin
        sckEdge = (state == ST_MSHIFT) ? tick
            : ((state == ST_SSHIFT) && (sckSync != sckPrev));
        sampleEdge = sckEdge && (edgeIdx[0] == clockPhase);
        inBit = (state == ST_MSHIFT) ? misoSync : mosiSync;
        capture = {shiftReg[6:0], inBit};
        // Phase 0 ends on a shift edge, when the byte is already whole
        pushByte = sampleEdge ? capture : shiftReg;
        xferDone = sckEdge && (edgeIdx == `LAST_EDGE);

        next_rateSel = rateSel;
        next_clockPhase = clockPhase;
        next_clockPolarity = clockPolarity;
        next_selectPinDisable = selectPinDisable;
        next_peripheralEnable = peripheralEnable;
        next_masterSelect = masterSelect;
        next_state = state;
        next_shiftReg = shiftReg;
        next_edgeIdx = edgeIdx;
        next_sckPhase = sckPhase;
        next_mosiOut = mosiOut;
        next_slaveArmed = slaveArmed;
        next_statusSeen = statusSeen;
        next_transferDone = transferDone;
        next_modeFault = modeFault;
        next_writeCollision = writeCollision;

        if (ctrlWr) begin
            next_rateSel = {ctrlIn[`CTRL_RATE2_BIT], ctrlIn[`CTRL_RATE1_BIT],
                ctrlIn[`CTRL_RATE0_BIT]};
            next_clockPhase = ctrlIn[`CTRL_PHASE_BIT];
            next_clockPolarity = ctrlIn[`CTRL_POLARITY_BIT];
            next_selectPinDisable = ctrlIn[`CTRL_SELECT_PIN_DISABLE_BIT];
            next_peripheralEnable = ctrlIn[`CTRL_ENABLE_BIT];
            next_masterSelect = ctrlIn[`CTRL_MASTER_BIT];
            if (statusSeen) begin
                next_modeFault = 1'b0;
            end
        end

        // Shifting: sample edges take in, the others present the next bit
        if (sckEdge) begin
            next_edgeIdx = 4'(edgeIdx + 4'h1);
            next_sckPhase = !sckPhase;
            if (sampleEdge) begin
                next_shiftReg = capture;
            end else begin
                next_mosiOut = shiftReg[7];
            end
        end
        if (xferDone) begin
            next_state = ST_IDLE;
            next_edgeIdx = 4'h0;
            next_slaveArmed = 1'b0;
        end

        // Slave byte starts once selected and preloaded
        if (state == ST_IDLE && !masterSelect && peripheralEnable
                && slaveArmed && slaveSelected) begin
            next_state = ST_SSHIFT;
            next_edgeIdx = 4'h0;
            next_sckPhase = 1'b0;
        end
        if (state == ST_SSHIFT && (!slaveSelected || masterSelect)) begin
            next_state = ST_IDLE;
            next_edgeIdx = 4'h0;
            next_sckPhase = 1'b0;
        end

        // Data register access
        if (statusSeen && (dataRd || dataWr)) begin
            next_transferDone = 1'b0;
            next_statusSeen = 1'b0;
        end
        if (dataWr) begin
            if (busy || (masterSelect && !fifoReady)) begin
                next_writeCollision = 1'b1;
            end else begin
                if (statusSeen) begin
                    next_writeCollision = 1'b0;
                end
                next_shiftReg = dataIn;
                next_mosiOut = dataIn[7];
                next_edgeIdx = 4'h0;
                next_sckPhase = 1'b0;
                if (masterSelect && peripheralEnable) begin
                    next_state = ST_MSHIFT;
                end else if (!masterSelect) begin
                    next_slaveArmed = 1'b1;
                end
            end
        end
        if (statusRd) begin
            next_statusSeen = 1'b1;
        end
        if (xferDone) begin
            next_transferDone = 1'b1;
        end

        if (faultEvent) begin
            next_modeFault = 1'b1;
            next_peripheralEnable = 1'b0;
            next_masterSelect = 1'b0;
            next_state = ST_IDLE;
            next_edgeIdx = 4'h0;
            next_sckPhase = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rateSel <= 3'h0;
            clockPhase <= 1'b0;
            clockPolarity <= 1'b0;
            selectPinDisable <= 1'b0;
            peripheralEnable <= 1'b0;
            masterSelect <= 1'b0;
            state <= ST_IDLE;
            shiftReg <= 8'h00;
            edgeIdx <= 4'h0;
            sckPhase <= 1'b0;
            mosiOut <= 1'b0;
            slaveArmed <= 1'b0;
            statusSeen <= 1'b0;
            transferDone <= 1'b0;
            modeFault <= 1'b0;
            writeCollision <= 1'b0;
        end else begin
            rateSel <= next_rateSel;
            clockPhase <= next_clockPhase;
            clockPolarity <= next_clockPolarity;
            selectPinDisable <= next_selectPinDisable;
            peripheralEnable <= next_peripheralEnable;
            masterSelect <= next_masterSelect;
            state <= next_state;
            shiftReg <= next_shiftReg;
            edgeIdx <= next_edgeIdx;
            sckPhase <= next_sckPhase;
            mosiOut <= next_mosiOut;
            slaveArmed <= next_slaveArmed;
            statusSeen <= next_statusSeen;
            transferDone <= next_transferDone;
            modeFault <= next_modeFault;
            writeCollision <= next_writeCollision;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    always_comb begin
        sckOut = peripheralEnable ? (clockPolarity ^ sckPhase) : 1'b1;
        sckOe = peripheralEnable && masterSelect;
        mosiOe = peripheralEnable && masterSelect;
        misoOut = mosiOut;
        misoOe = peripheralEnable && !masterSelect && slaveArmed
            && slaveSelected;
        spiRequest = transferDone || modeFault;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence master_launch;
        dataWr && masterSelect && peripheralEnable && !busy && fifoReady
            && !faultEvent;
    endsequence

    sequence first_bit_out;
        ##1 (state == ST_MSHIFT) && (mosiOut == $past(dataIn[7]));
    endsequence

    launch_msb_a: assert property (master_launch |-> first_bit_out)
        else $error("master write did not launch with msb");
    eight_cycles_a: assert property (xferDone |-> edgeIdx == 4'hF
        && sckPhase)
        else $error("byte ended before sixteen edges");
    done_set_a: assert property (xferDone |=> transferDone)
        else $error("done flag not set after byte");
    done_clear_a: assert property (statusSeen && dataRd && !xferDone
        |=> !transferDone)
        else $error("done flag not cleared by data access");
    collision_a: assert property (dataWr && busy |=> writeCollision
        && (shiftReg == $past(shiftReg) || $past(sampleEdge)))
        else $error("write during transfer not refused");
    fault_mode_a: assert property (faultEvent |=> modeFault
        && !peripheralEnable && !masterSelect && state == ST_IDLE)
        else $error("mode fault did not drop to slave");
    idle_high_a: assert property (!peripheralEnable |-> sckOut)
        else $error("disabled clock not idle high");
    idle_level_a: assert property (peripheralEnable && !busy
        && $stable(clockPolarity) [*2] |-> sckOut == clockPolarity)
        else $error("idle clock level wrong");
    slave_drive_a: assert property (misoOe |-> !mosiOe)
        else $error("both data lines driven");
    phase_gate_a: assert property (!masterSelect && !clockPhase
        |-> !ssPinRelease)
        else $error("select freed with phase zero");
    slave_load_a: assert property (state == ST_IDLE && !masterSelect
        && !slaveArmed |=> state != ST_SSHIFT)
        else $error("slave shifted without preload");
endmodule // spi_ctrl
`default_nettype wire

// *** spi_peer_model.sv ***
// Behavioural slave peripheral on the far side of the serial bus.
// Assumes the master runs clock polarity 0 and clock phase 0.
`timescale 1ns/1ns
`default_nettype none
module spi_peer_model (
    input wire logic sck,
    input wire logic mosi,
    input wire logic selN,
    input wire logic [7:0] txByte,
    output logic miso,
    output logic [7:0] rxByte
);
    logic [7:0] shift = 8'h00;
    initial miso = 1'h0;
    initial rxByte = 8'h00;
    // Present the first bit as soon as selected
    always @(negedge selN) begin
        shift = txByte;
        miso = shift[7];
    end
    always @(posedge sck) begin
        if (!selN) begin
            rxByte = {rxByte[6:0], mosi};
        end
    end
    always @(negedge sck) begin
        if (!selN) begin
            shift = {shift[6:0], 1'h0};
            miso = shift[7];
        end
    end
    // Released line shows the inverse of its last bit
    always @(posedge selN) begin
        miso = ~miso;
    end
endmodule // spi_peer_model
`default_nettype wire

// *** tb_spi_master_slave_controller.sv ***
// Self-checking bench for the serial controller, master and slave side.
// Assumes the peer model answers on the data-in line in master mode.
`timescale 1ns/1ns
`default_nettype none
module tb_spi_master_slave_controller;
    import spi_pkg::*;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic ctrlWr = 1'h0, statusRd = 1'h0, dataWr = 1'h0, dataRd = 1'h0;
    byte_t ctrlIn = 8'h00, dataIn = 8'h00, rxData, peerTx = 8'h00, peerRx;
    logic rxValid, peripheralEnable, masterSelect, transferDone, modeFault;
    logic writeCollision, spiRequest, ssPinRelease, sckOut, sckOe;
    logic mosiOut, mosiOe, misoOut, misoOe, peerMiso;
    logic ssIn = 1'h1, sckIn = 1'h0, mosiIn = 1'h0, peerSelN = 1'h1;
    int mismatches = 0, nCompared = 0;
    byte_t expQ[$];

    always #25 clk = ~clk;

    spi_ctrl u_dut (.clk(clk), .rst_n(rst_n), .ctrlWr(ctrlWr),
        .ctrlIn(ctrlIn), .statusRd(statusRd), .dataWr(dataWr),
        .dataIn(dataIn), .dataRd(dataRd), .rxData(rxData),
        .rxValid(rxValid), .peripheralEnable(peripheralEnable),
        .masterSelect(masterSelect), .transferDone(transferDone),
        .modeFault(modeFault), .writeCollision(writeCollision),
        .spiRequest(spiRequest), .ssPinRelease(ssPinRelease),
        .ssIn(ssIn), .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe),
        .mosiIn(mosiIn), .mosiOut(mosiOut), .mosiOe(mosiOe),
        .misoIn(peerMiso), .misoOut(misoOut), .misoOe(misoOe));

    spi_peer_model u_peer (.sck(sckOut), .mosi(mosiOut), .selN(peerSelN),
        .txByte(peerTx), .miso(peerMiso), .rxByte(peerRx));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
            input string msg);
        nCompared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %0t %s", $time, msg);
        end
    endtask

    task automatic wrCtrl(input byte_t b);
        ctrlIn = b;
        ctrlWr = 1'h1;
        tick();
        ctrlWr = 1'h0;
        tick();
    endtask

    task automatic wrData(input byte_t b);
        dataIn = b;
        dataWr = 1'h1;
        tick();
        dataWr = 1'h0;
    endtask

    task automatic rdStatus();
        statusRd = 1'h1;
        tick();
        statusRd = 1'h0;
        tick();
    endtask

    task automatic rdData();
        dataRd = 1'h1;
        tick();
        dataRd = 1'h0;
        tick();
    endtask

    function automatic byte_t ctl(input logic en, ms, dis, pol, ph,
            input logic [2:0] r);
        return {r[2], en, dis, ms, pol, ph, r[1], r[0]};
    endfunction

    // Half period in clk cycles; code 7 runs as divide by two
    function automatic int halfPer(input int c);
        return (c == 7) ? 1 : (1 << c);
    endfunction

    task automatic waitDone(input int lim);
        int n;
        n = 0;
        while (transferDone !== 1'h1 && n < lim) begin
            tick();
            n++;
        end
    endtask

    // Master byte with a fresh peer byte; a stray write lands at code 3
    task automatic mxfer(input int c, input byte_t d, input logic pop);
        int n, edges, first, last;
        logic prev;
        n = 0;
        edges = 0;
        first = 0;
        last = 0;
        peerSelN = 1'h1;
        rdStatus();
        peerTx = 8'($urandom);
        peerSelN = 1'h0;
        expQ.push_back(peerTx);
        wrData(d);
        dataIn = ~d;
        prev = sckOut;
        while (transferDone !== 1'h1 && n < 3000) begin
            tick();
            n++;
            if (sckOut === 1'h1 && prev === 1'h0) begin
                if (edges == 0) first = n;
                last = n;
                edges++;
            end
            prev = sckOut;
            dataWr = (n == 3 && c == 3);
        end
        chk(16'(edges), 16'h0008, "clock edge count");
        chk(16'(last - first), 16'(14 * halfPer(c)), "bit period");
        chk(peerRx, d, "byte at slave");
        chk({transferDone, spiRequest}, 2'h3, "done flag");
        chk(writeCollision, 1'(c == 3), "collision flag");
        chk(rxValid, 1'h1, "receive buffer");
        rdStatus();
        if (pop) begin
            if (c >= 2 && c < 7) chk(rxData, expQ[0], "byte in");
            void'(expQ.pop_front());
            rdData();
            tick();
            chk(transferDone, 1'h0, "done cleared");
            chk(rxValid, 1'h0, "buffer empty");
        end
    endtask

    task automatic end_of_test();
        if (mismatches == 0 && nCompared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        byte_t sd, md;
        void'($urandom(95));
        repeat (10) tick();
        rst_n = 1'h1;
        tick();
        chk(sckOut, 1'h1, "idle clock at reset");
        chk({transferDone, modeFault, writeCollision, rxValid}, 4'h0,
            "flags at reset");
        chk({sckOe, mosiOe, misoOe}, 3'h0, "drivers at reset");
        for (int c = 0; c < 8; c++) begin
            wrCtrl(ctl(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 3'(c)));
            chk(masterSelect, 1'h1, "master mode");
            chk({sckOut, sckOe, mosiOe, misoOe}, 4'h6, "master pins");
            mxfer(c, 8'($urandom), 1'h1);
        end
        wrCtrl(ctl(1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 3'h2));
        chk(sckOut, 1'h1, "idle high clock");
        wrCtrl(ctl(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 3'h2));
        repeat (16) mxfer(2, 8'($urandom), 1'h0);
        wrData(8'hA5);
        repeat (4) tick();
        chk({writeCollision, sckOut}, 2'h2, "full buffer refuses");
        for (int i = 0; i < 16; i++) begin
            chk({rxValid, rxData}, {1'h1, expQ.pop_front()}, "drain");
            rdData();
        end
        tick();
        chk(rxValid, 1'h0, "drained empty");
        for (int k = 0; k < 3; k++) begin
            wrCtrl(ctl(1'h0, 1'(k == 0), 1'h1, 1'h0, 1'(k == 2), 3'h0));
            chk(ssPinRelease, 1'(k != 1), "select release");
        end
        wrCtrl(ctl(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 3'h2));
        ssIn = 1'h0;
        repeat (6) tick();
        chk({modeFault, peripheralEnable, masterSelect}, 3'h4, "fault");
        chk({sckOut, spiRequest}, 2'h3, "fault idle");
        ssIn = 1'h1;
        rdStatus();
        wrCtrl(8'h00);
        chk(modeFault, 1'h0, "fault cleared");
        for (int ph = 0; ph < 2; ph++) begin
            wrCtrl(ctl(1'h1, 1'h0, 1'(ph), 1'h0, 1'(ph), 3'h0));
            sd = 8'($urandom);
            md = 8'($urandom);
            rdStatus();
            wrData(sd);
            ssIn = 1'(ph);
            for (int i = 7; i >= 0; i--) begin
                if (ph == 1) sckIn = 1'h1;
                mosiIn = md[i];
                repeat (16) tick();
                chk({misoOe, misoOut}, {1'h1, sd[i]}, "slave out bit");
                sckIn = ~sckIn;
                repeat (16) tick();
                if (ph == 0) sckIn = 1'h0;
            end
            waitDone(64);
            chk(transferDone, 1'h1, "slave done");
            chk(rxData, md, "slave in byte");
            rdData();
        end
        ssIn = 1'h1;
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("unexpected %0t watchdog expired", $time);
        end_of_test();
    end
endmodule // tb_spi_master_slave_controller
`default_nettype wire
